// *** rtl/cirb_pkg.sv ***
// constants, carriers and helpers for the can interrupt and bus-off recovery block
// assumes a 32-bit axi4-lite slave port and an external frame engine
package cirb_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_RFLG = 8'h04;
   localparam logic [7:0] OFS_RIER = 8'h08;
   localparam logic [7:0] OFS_TFLG = 8'h0c;
   localparam logic [7:0] OFS_TIER = 8'h10;
   localparam logic [7:0] OFS_MISC = 8'h14;
   localparam logic [7:0] OFS_STAT = 8'h18;

   // control_register_1 field positions
   localparam int CB_EN     = 0;
   localparam int CB_INIT   = 1;
   localparam int CB_SLP    = 2;
   localparam int CB_BUS_WAKEUP_ENABLE   = 3;
   localparam int CB_BUSOFF_RECOVERY_SELECT   = 4;
   localparam int CB_INIT_ACKNOWLEDGE = 8;
   localparam int CB_SLEEP_ACKNOWLEDGE  = 9;

   // receiver_flag_register and enable field positions
   localparam int RB_RXF = 0;
   localparam int RB_OVR = 1;
   localparam int RB_TST = 2;
   localparam int RB_RST = 4;
   localparam int RB_CSC = 6;
   localparam int RB_WUP = 7;
   localparam int MB_HOLD = 0;

   // reset values and the receiver enable write mask
   localparam logic [4:0] CTRL_RST = 5'h02;
   localparam logic [2:0] TXE_RST  = 3'h7;
   localparam logic [7:0] RIER_MASK = 8'hc3;

   // error state codes and counter limits
   localparam logic [1:0] ST_OK   = 2'h0;
   localparam logic [1:0] ST_WARN = 2'h1;
   localparam logic [1:0] ST_ERR  = 2'h2;
   localparam logic [1:0] ST_OFF  = 2'h3;
   localparam logic [8:0] LIM_WARN = 9'h060;
   localparam logic [8:0] LIM_ERR  = 9'h080;

   // recovery needs this many runs of recessive bits
   localparam int RECOV_COUNT    = 128;
   localparam int RECESSIVE_BITS = 11;

   localparam logic [1:0] RESP_OK     = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum {BO_ACTIVE, BO_OFF} cirb_bo_e;

   // status from the frame engine
   typedef struct packed {
      logic       rx_frame_done;
      logic       rx_fifo_pending;
      logic       rx_overrun;
      logic [2:0] tx_done;
      logic [8:0] tec;
      logic [7:0] rec;
      logic       recessive_11;
      logic       bus_idle;
      logic       bus_activity;
   } cirb_eng_s;

   // commands to the frame engine
   typedef struct packed {
      logic       run;
      logic       rx_shift;
      logic [2:0] tx_sched;
      logic       recover;
   } cirb_ctl_s;

   // counter value to bus state
   function automatic logic [1:0] cirb_level(input logic [8:0] cnt);
      cirb_level = (cnt >= LIM_ERR) ? ST_ERR : (cnt >= LIM_WARN) ? ST_WARN : ST_OK;
   endfunction : cirb_level

   // word-aligned address match
   function automatic logic cirb_hit(input logic [7:0] a, input logic [7:0] ofs);
      cirb_hit = (a[7:2] == ofs[7:2]);
   endfunction : cirb_hit

endpackage : cirb_pkg

// *** rtl/cirb_busoff.sv ***
// bus-off state and recovery counting
// assumes the engine clears its transmit counter at the edge of recover
`timescale 1ns/1ps
module cirb_busoff import cirb_pkg::*; #(
   parameter int RECOV_N = RECOV_COUNT
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       ce,
   input  wire logic       run,
   input  wire logic       off_cond,
   input  wire logic       recessive_11,
   input  wire logic       busoff_recovery_select,
   input  wire logic       hold,
   output logic            busoff,
   output logic            enter,
   output logic            recover,
   output logic [7:0]      cnt
);
   cirb_bo_e   state_reg;
   logic [7:0] cnt_reg;
   logic       done;

   // counting stalls while the module clocks are stopped
   assign done    = (cnt_reg == 8'(RECOV_N));
   assign enter   = (state_reg == BO_ACTIVE) && run && off_cond;
   assign recover = (state_reg == BO_OFF) && run && done && (!busoff_recovery_select || !hold);
   assign busoff  = (state_reg == BO_OFF);
   assign cnt     = cnt_reg;

   // state and run counter
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= BO_ACTIVE;
         cnt_reg   <= 8'h00;
      end
      else if (ce)
      begin
         case (state_reg)
            BO_ACTIVE:
            begin
               cnt_reg <= 8'h00;
               if (enter)
                  state_reg <= BO_OFF;
            end
            default:
            begin
               if (run && recessive_11 && !done)
                  cnt_reg <= cnt_reg + 8'h01;
               if (recover)
                  state_reg <= BO_ACTIVE;
            end
         endcase
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_auto_leave;
      ce && busoff && run && done && !busoff_recovery_select |=> !busoff;
   endproperty
   a_auto_leave: assert property (p_auto_leave) else $error("auto recovery missed");

   property p_hold_blocks;
      ce && busoff && busoff_recovery_select && hold |=> busoff;
   endproperty
   a_hold_blocks: assert property (p_hold_blocks) else $error("left bus-off while held");

   property p_count_first;
      recover |-> cnt_reg == 8'(RECOV_N);
   endproperty
   a_count_first: assert property (p_count_first) else $error("recovery before count");

   c_recover: cover property (ce && recover && busoff_recovery_select);
endmodule : cirb_busoff

// *** rtl/cirb_ctrl.sv ***
// can interrupt flags, mode handshakes and bus-off recovery control
// assumes a frame engine drives eng and obeys ctl; axi4-lite on aclk
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
module cirb_ctrl import cirb_pkg::*; #(
   parameter int RECOV_N = RECOV_COUNT
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire cirb_eng_s   eng,
   output cirb_ctl_s        ctl,
   input  wire logic        pwr_down,
   input  wire logic        rxd_in,
   output logic             rxd_int,
   output logic             irq_tx,
   output logic             irq_rx,
   output logic             irq_err,
   output logic             irq_wake
);
   // bus slave state
   logic        aw_ok_reg;
   logic        w_ok_reg;
   logic [7:0]  aw_addr_reg;
   logic [7:0]  w_data_reg;
   logic        w_lane_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rd_mux;
   logic        rd_hit;

   // control and flags
   logic [4:0]  ctrl_reg;
   logic [4:0]  ctrl_next;
   logic        init_ack_reg;
   logic        slp_ack_reg;
   logic        bus_wakeup_enable_armed_reg;
   logic        rxf_reg;
   logic        ovr_reg;
   logic        csc_reg;
   logic        wup_reg;
   logic [1:0]  tx_state_field_reg;
   logic [1:0]  rx_state_field_reg;
   logic [7:0]  rier_reg;
   logic [2:0]  tier_reg;
   logic [2:0]  txe_reg;
   logic        hold_reg;

   logic        wr_fire;
   logic        w_ctrl;
   logic        w_rflg;
   logic        w_rier;
   logic        w_tflg;
   logic        w_tier;
   logic        w_misc;
   logic        wr_hit;
   logic        run;
   logic        shift_go;
   logic        rxf_set;
   logic        ovr_set;
   logic        csc_set;
   logic        wake_ev;
   logic [2:0]  txe_clr;
   logic [1:0]  tx_new;
   logic [1:0]  rx_new;
   logic        bo_busoff;
   logic        bo_enter;
   logic        bo_recover;
   logic [7:0]  bo_cnt;
   logic        slp_enter;

   // handshake readies drop while frozen so no beat is lost
   assign s_axi_awready = ce && !aw_ok_reg && !bvalid_reg;
   assign s_axi_wready  = ce && !w_ok_reg && !bvalid_reg;
   assign s_axi_arready = ce && !rvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   // write decode; only byte lane 0 carries writable fields
   assign wr_fire = ce && aw_ok_reg && w_ok_reg;
   assign w_ctrl  = wr_fire && w_lane_reg && cirb_hit(aw_addr_reg, OFS_CTRL);
   assign w_rflg  = wr_fire && w_lane_reg && cirb_hit(aw_addr_reg, OFS_RFLG);
   assign w_rier  = wr_fire && w_lane_reg && cirb_hit(aw_addr_reg, OFS_RIER);
   assign w_tflg  = wr_fire && w_lane_reg && cirb_hit(aw_addr_reg, OFS_TFLG);
   assign w_tier  = wr_fire && w_lane_reg && cirb_hit(aw_addr_reg, OFS_TIER);
   assign w_misc  = wr_fire && w_lane_reg && cirb_hit(aw_addr_reg, OFS_MISC);
   assign wr_hit  = aw_addr_reg[7:2] <= OFS_STAT[7:2]; // whole status word answers okay

   // write address and data latches, response after both
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ok_reg   <= 1'b0;
         w_ok_reg    <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 8'h00;
         w_lane_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OK;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ok_reg   <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ok_reg   <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_lane_reg <= s_axi_wstrb[0];
         end
         if (wr_fire)
         begin
            aw_ok_reg  <= 1'b0;
            w_ok_reg   <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? RESP_OK : RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_reg <= 1'b0;
      end
   end

   // read decode
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      if (cirb_hit(s_axi_araddr, OFS_CTRL))
         rd_mux = {22'h0, slp_ack_reg, init_ack_reg, 3'h0, ctrl_reg};
      else if (cirb_hit(s_axi_araddr, OFS_RFLG))
         rd_mux = {24'h0, wup_reg, csc_reg, rx_state_field_reg, tx_state_field_reg, ovr_reg, rxf_reg};
      else if (cirb_hit(s_axi_araddr, OFS_RIER))
         rd_mux = {24'h0, rier_reg};
      else if (cirb_hit(s_axi_araddr, OFS_TFLG))
         rd_mux = {29'h0, txe_reg};
      else if (cirb_hit(s_axi_araddr, OFS_TIER))
         rd_mux = {29'h0, tier_reg};
      else if (cirb_hit(s_axi_araddr, OFS_MISC))
         rd_mux = {31'h0, hold_reg};
      else if (cirb_hit(s_axi_araddr, OFS_STAT))
         rd_mux = {16'h0, bo_cnt, 7'h0, bo_busoff};
      else
         rd_hit = 1'b0;
   end

   // read channel, one beat at a time
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= RESP_OK;
      end
      else if (ce)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= rd_hit ? RESP_OK : RESP_SLVERR;
         end
         else if (s_axi_rready)
            rvalid_reg <= 1'b0;
      end
   end

   // module clocks stop when disabled, asleep or powered down
   assign run = ctrl_reg[CB_EN] && !slp_ack_reg && !pwr_down;

   // sleep needs empty tx buffers and an idle bus
   assign slp_enter = run && ctrl_reg[CB_SLP] && (&txe_reg) && eng.bus_idle;

   // wake only from an armed sleep, also after power down
   assign wake_ev = ctrl_reg[CB_EN] && slp_ack_reg && bus_wakeup_enable_armed_reg && eng.bus_activity;

   // unarmed sleep masks the bus so nothing can wake it
   assign rxd_int = rxd_in || (slp_ack_reg && !bus_wakeup_enable_armed_reg);

   // sleep request cannot be withdrawn before it is acknowledged
   always_comb
   begin
      ctrl_next = ctrl_reg;
      if (w_ctrl)
      begin
         ctrl_next = w_data_reg[4:0];
         if (ctrl_reg[CB_SLP] && !slp_ack_reg)
            ctrl_next[CB_SLP] = 1'b1;
      end
      if (wake_ev)
         ctrl_next[CB_SLP] = 1'b0;
   end

   // control and mode handshakes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg       <= CTRL_RST;
         init_ack_reg   <= 1'b0;
         slp_ack_reg    <= 1'b0;
         bus_wakeup_enable_armed_reg <= 1'b0;
      end
      else if (ce)
      begin
         ctrl_reg     <= ctrl_next;
         init_ack_reg <= ctrl_reg[CB_EN] && ctrl_reg[CB_INIT];
         if (slp_enter)
         begin
            slp_ack_reg    <= 1'b1;
            bus_wakeup_enable_armed_reg <= ctrl_reg[CB_BUS_WAKEUP_ENABLE];
         end
         else if (wake_ev || !ctrl_reg[CB_SLP] || !ctrl_reg[CB_EN])
            slp_ack_reg <= 1'b0;
      end
   end

   // receive path: frame end or a queued message fills the foreground
   assign shift_go = run && !rxf_reg && eng.rx_fifo_pending && !eng.rx_frame_done;
   assign rxf_set  = (run && eng.rx_frame_done) || shift_go;
   assign ovr_set  = run && eng.rx_overrun;

   // state codes; bus-off overrides the tx counter level
   assign tx_new  = bo_busoff ? ST_OFF : cirb_level(eng.tec);
   assign rx_new  = cirb_level({1'b0, eng.rec});
   assign csc_set = run && ((tx_new != tx_state_field_reg) || (rx_new != rx_state_field_reg));

   // a tx buffer that finishes cannot be cleared in the same cycle
   assign txe_clr = (w_tflg ? w_data_reg[2:0] : 3'h0) & ~eng.tx_done;

   // flags: set wins over a write-one clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rxf_reg   <= 1'b0;
         ovr_reg   <= 1'b0;
         csc_reg   <= 1'b0;
         wup_reg   <= 1'b0;
         tx_state_field_reg <= ST_OK;
         rx_state_field_reg <= ST_OK;
         txe_reg   <= TXE_RST;
         hold_reg  <= 1'b0;
      end
      else if (ce)
      begin
         rxf_reg <= rxf_set || (rxf_reg && !(w_rflg && w_data_reg[RB_RXF]));
         ovr_reg <= ovr_set || (ovr_reg && !(w_rflg && w_data_reg[RB_OVR]));
         csc_reg <= csc_set || (csc_reg && !(w_rflg && w_data_reg[RB_CSC]));
         wup_reg <= wake_ev || (wup_reg && !(w_rflg && w_data_reg[RB_WUP]));
         txe_reg <= eng.tx_done | (txe_reg & ~txe_clr);
         hold_reg <= (bo_enter && ctrl_reg[CB_BUSOFF_RECOVERY_SELECT]) || (hold_reg && !(w_misc && w_data_reg[MB_HOLD]));
         if (csc_set)
         begin
            tx_state_field_reg <= tx_new;
            rx_state_field_reg <= rx_new;
         end
      end
   end

   // enables
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rier_reg <= 8'h00;
         tier_reg <= 3'h0;
      end
      else if (ce)
      begin
         if (w_rier)
            rier_reg <= w_data_reg & RIER_MASK;
         if (w_tier)
            tier_reg <= w_data_reg[2:0];
      end
   end

   // bus-off state machine and recovery count
   cirb_busoff #(
      .RECOV_N      (RECOV_N)
   ) u_busoff (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .ce           (ce),
      .run          (run),
      .off_cond     (eng.tec[8]),
      .recessive_11 (eng.recessive_11),
      .busoff_recovery_select         (ctrl_reg[CB_BUSOFF_RECOVERY_SELECT]),
      .hold         (hold_reg),
      .busoff       (bo_busoff),
      .enter        (bo_enter),
      .recover      (bo_recover),
      .cnt          (bo_cnt)
   );

   // requests stay up as long as an enabled flag stays set
   assign irq_tx   = |(txe_reg & tier_reg);
   assign irq_rx   = rxf_reg && rier_reg[RB_RXF];
   assign irq_err  = (csc_reg && rier_reg[RB_CSC]) || (ovr_reg && rier_reg[RB_OVR]);
   assign irq_wake = wup_reg && rier_reg[RB_WUP];

   // engine commands
   assign ctl.run      = run;
   assign ctl.rx_shift = shift_go;
   assign ctl.tx_sched = ~txe_reg;
   assign ctl.recover  = bo_recover;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_txe_set;
      ce && eng.tx_done[1] && tier_reg[1] && !w_tier |=> txe_reg[1] && irq_tx;
   endproperty
   a_txe_set: assert property (p_txe_set) else $error("tx empty not raised");

   property p_rxf_eof;
      ce && run && eng.rx_frame_done |=> rxf_reg;
   endproperty
   a_rxf_eof: assert property (p_rxf_eof) else $error("rx full missed frame end");

   property p_rxf_shift;
      ce && run && !rxf_reg && eng.rx_fifo_pending |-> ctl.rx_shift || eng.rx_frame_done ##1 rxf_reg;
   endproperty
   a_rxf_shift: assert property (p_rxf_shift) else $error("queued message not shifted");

   property p_wake;
      ce && wake_ev |=> wup_reg && !slp_ack_reg && !ctrl_reg[CB_SLP];
   endproperty
   a_wake: assert property (p_wake) else $error("wake not taken");

   property p_wake_cause;
      ce && !wup_reg ##1 wup_reg |-> $past(slp_ack_reg) && $past(bus_wakeup_enable_armed_reg);
   endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("wake without armed sleep");

   property p_ovr;
      ce && run && eng.rx_overrun && rier_reg[RB_OVR] && !w_rier |=> ovr_reg && irq_err;
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun not flagged");

   property p_csc;
      ce && run && eng.tec >= LIM_WARN && tx_state_field_reg == ST_OK && !bo_busoff |=> csc_reg;
   endproperty
   a_csc: assert property (p_csc) else $error("warning entry not flagged");

   property p_state_fields;
      ce && csc_set |=> tx_state_field_reg == $past(tx_new) && rx_state_field_reg == $past(rx_new);
   endproperty
   a_state_fields: assert property (p_state_fields) else $error("state fields stale");

   property p_pending;
      rxf_reg && rier_reg[RB_RXF] && !wr_fire |=> irq_rx;
   endproperty
   a_pending: assert property (p_pending) else $error("rx request dropped");

   property p_w1c;
      ce && w_rflg && w_data_reg[RB_OVR] && !ovr_set |=> !ovr_reg;
   endproperty
   a_w1c: assert property (p_w1c) else $error("write one did not clear");

   property p_w0_keep;
      ce && w_rflg && !w_data_reg[RB_CSC] && csc_reg |=> csc_reg;
   endproperty
   a_w0_keep: assert property (p_w0_keep) else $error("write zero cleared");

   property p_set_wins;
      ce && w_rflg && w_data_reg[RB_RXF] && rxf_set |=> rxf_reg;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat a live condition");

   property p_recover_cmd;
      ce && bo_busoff && run && bo_cnt == 8'(RECOV_N) && !ctrl_reg[CB_BUSOFF_RECOVERY_SELECT] |-> ctl.recover;
   endproperty
   a_recover_cmd: assert property (p_recover_cmd) else $error("recovery not issued");

   property p_hold_set;
      ce && bo_enter && ctrl_reg[CB_BUSOFF_RECOVERY_SELECT] |=> hold_reg ##1 !ctl.recover;
   endproperty
   a_hold_set: assert property (p_hold_set) else $error("hold not set on bus-off");

   property p_disabled;
      !ctrl_reg[CB_EN] |-> !ctl.run && !ctl.rx_shift && !slp_enter;
   endproperty
   a_disabled: assert property (p_disabled) else $error("activity while disabled");

   property p_rx_mask;
      slp_ack_reg && !bus_wakeup_enable_armed_reg |-> rxd_int && !wake_ev;
   endproperty
   a_rx_mask: assert property (p_rx_mask) else $error("bus not masked asleep");

   property p_irq_or;
      ce && eng.tx_done[0] && tier_reg[0] && !w_tier |=> irq_tx;
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("tx request missing");

   c_sleep_wake: cover property (ce && slp_enter ##[1:50] wake_ev);
   c_rx_chain: cover property (ce && eng.rx_frame_done ##[1:20] ctl.rx_shift);
   c_busoff: cover property (bo_enter ##[1:1000] bo_recover);
endmodule : cirb_ctrl

// *** verification/cirb_eng_model.sv ***
// frame engine stand-in on the controller's engine link
// assumes bench event inputs are one-cycle pulses
`timescale 1ns/1ps
module cirb_eng_model import cirb_pkg::*; (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire cirb_ctl_s  ctl,
   input  wire logic       frame_ev,
   input  wire logic       queue_ev,
   input  wire logic       act_ev,
   input  wire logic       ovr_ev,
   input  wire logic       tec_ld,
   input  wire logic [8:0] tec_val,
   output cirb_eng_s       eng
);
   logic [3:0] pend_reg;
   logic [8:0] tec_reg;
   logic [3:0] gap_reg;
   // queue depth, error count, bit pacing; recover wipes tec
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pend_reg <= 4'h0;
         tec_reg  <= 9'h000;
         gap_reg  <= 4'h0;
      end
      else
      begin
         pend_reg <= pend_reg + {3'h0, queue_ev} - {3'h0, ctl.rx_shift};
         tec_reg  <= tec_ld ? tec_val : (ctl.recover ? 9'h000 : tec_reg);
         gap_reg  <= (gap_reg == 4'ha) ? 4'h0 : gap_reg + 4'h1;
      end
   end
   // one run per 11 bit times; sends finish when gap_reg is 0, 0 to 10 cycles after being scheduled
   assign eng.rx_frame_done   = frame_ev;
   assign eng.rx_fifo_pending = (pend_reg != 4'h0);
   assign eng.rx_overrun      = ovr_ev;
   assign eng.tx_done         = ctl.tx_sched & {3{gap_reg == 4'h0}};
   assign eng.tec             = tec_reg;
   assign eng.rec             = 8'h00;
   assign eng.recessive_11    = (gap_reg == 4'ha);
   assign eng.bus_idle        = 1'b1;
   assign eng.bus_activity    = act_ev;
endmodule : cirb_eng_model

// *** verification/cirb_ctrl_tb.sv ***
// self-checking bench for cirb_ctrl
// assumes RECOV_N of 4 and the engine stand-in beside it
`timescale 1ns/1ps
module cirb_ctrl_tb import cirb_pkg::*;;
   logic        aclk, aresetn, ce, pwr_down, rxd_in, rxd_int, frame_ev, queue_ev, act_ev, tec_ld, ovr_ev;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_tx, irq_rx, irq_err, irq_wake;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [8:0]  tec_val;
   cirb_eng_s   eng;
   cirb_ctl_s   ctl;
   int          failures, n_checks, cyc;
   localparam logic [31:0] ALL = 32'hffff_ffff;
   cirb_ctrl #(.RECOV_N(4)) uut (.*);
   cirb_eng_model eng_m (.*);
   // free-running clock, 100 ns period
   always #50 aclk = ~aclk;
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         failures++;
      end
   endtask : chk
   // both write channels offered together, bready held high
   task wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
   endtask : wr
   // read and compare the masked word
   task rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      chk($sformatf("reg_%h", a), exp, s_axi_rdata & m);
   endtask : rdc
   task tec(input logic [8:0] v);
      tec_val <= v;
      tec_ld  <= 1'b1;
      @(posedge aclk);
      tec_ld  <= 1'b0;
      @(posedge aclk);
   endtask : tec
   task act;
      act_ev <= 1'b1;
      @(posedge aclk);
      act_ev <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask : act
   task t_reset;
      rdc(OFS_CTRL, 32'h0000_0002, ALL);
      rdc(OFS_TFLG, 32'h0000_0007, ALL);
      chk("irq_tx", 32'h0, {31'h0, irq_tx});
      wr(8'h40, 32'h0000_0001);
      chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, s_axi_bresp});
      wr(OFS_CTRL, 32'h0000_0003);
      repeat (2) @(posedge aclk);
      rdc(OFS_CTRL, 32'h0000_0103, ALL);
      wr(OFS_CTRL, 32'h0000_0001);
      $display("reset and init test done");
   endtask : t_reset
   task t_tx;
      wr(OFS_TIER, 32'h0000_0007);
      chk("irq_tx", 32'h1, {31'h0, irq_tx});
      wr(OFS_TFLG, 32'h0000_0003);
      chk("irq_tx", 32'h1, {31'h0, irq_tx});
      repeat (14) @(posedge aclk);
      rdc(OFS_TFLG, 32'h0000_0007, ALL);
      $display("tx test done");
   endtask : t_tx
   task t_rx;
      wr(OFS_RIER, 32'h0000_0001);
      frame_ev <= 1'b1;
      queue_ev <= 1'b1;
      @(posedge aclk);
      frame_ev <= 1'b0;
      queue_ev <= 1'b0;
      @(posedge aclk);
      rdc(OFS_RFLG, 32'h1, 32'h1);
      chk("irq_rx", 32'h1, {31'h0, irq_rx});
      wr(OFS_RFLG, 32'h0000_0000);
      rdc(OFS_RFLG, 32'h1, 32'h1);
      wr(OFS_RFLG, 32'h0000_0001);
      repeat (2) @(posedge aclk);
      rdc(OFS_RFLG, 32'h1, 32'h1);
      wr(OFS_RFLG, 32'h0000_0001);
      rdc(OFS_RFLG, 32'h0, 32'h1);
      chk("irq_rx", 32'h0, {31'h0, irq_rx});
      wr(OFS_RIER, 32'h0000_0002);
      ovr_ev <= 1'b1;
      @(posedge aclk);
      ovr_ev <= 1'b0;
      @(posedge aclk);
      chk("irq_err", 32'h1, {31'h0, irq_err});
      wr(OFS_RFLG, 32'h0000_0002);
      rdc(OFS_RFLG, 32'h0, 32'h2);
      $display("rx test done");
   endtask : t_rx
   task t_err;
      wr(OFS_RIER, 32'h0000_0040);
      tec(9'h060);
      rdc(OFS_RFLG, 32'h44, 32'h4c);
      chk("irq_err", 32'h1, {31'h0, irq_err});
      wr(OFS_RFLG, 32'h0000_0040);
      chk("irq_err", 32'h0, {31'h0, irq_err});
      tec(9'h100);
      rdc(OFS_STAT, 32'h1, 32'h1);
      repeat (60) @(posedge aclk);
      rdc(OFS_STAT, 32'h0, 32'h1);
      wr(OFS_CTRL, 32'h0000_0011);
      tec(9'h100);
      repeat (60) @(posedge aclk);
      rdc(OFS_STAT, 32'h1, 32'h1);
      wr(OFS_MISC, 32'h0000_0001);
      repeat (3) @(posedge aclk);
      rdc(OFS_STAT, 32'h0, 32'h1);
      $display("error and bus-off test done");
   endtask : t_err
   task t_sleep;
      // dominant line level so the masking shows on rxd_int
      rxd_in <= 1'b0;
      wr(OFS_CTRL, 32'h0000_0005);
      repeat (4) @(posedge aclk);
      rdc(OFS_CTRL, 32'h0000_0205, ALL);
      chk("rxd_int", 32'h1, {31'h0, rxd_int});
      act();
      rdc(OFS_RFLG, 32'h0, 32'h80);
      wr(OFS_CTRL, 32'h0000_0001);
      wr(OFS_RIER, 32'h0000_0080);
      wr(OFS_CTRL, 32'h0000_000d);
      repeat (4) @(posedge aclk);
      chk("rxd_int", 32'h0, {31'h0, rxd_int});
      act();
      rdc(OFS_RFLG, 32'h80, 32'h80);
      chk("irq_wake", 32'h1, {31'h0, irq_wake});
      $display("sleep and wake test done");
   endtask : t_sleep
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   // hang guard, far above the few hundred cycles needed
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         failures++;
         finish_test();
      end
   end
   initial
   begin
      {aclk, aresetn, pwr_down, frame_ev, queue_ev, act_ev, tec_ld, ovr_ev} = 8'h00;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = 19'h00000;
      {ce, s_axi_bready, s_axi_rready, rxd_in, s_axi_wstrb} = 8'hff;
      s_axi_wdata = 32'h0000_0000;
      tec_val = 9'h000;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_tx();
      t_rx();
      t_err();
      t_sleep();
      finish_test();
   end
endmodule : cirb_ctrl_tb
